// File: shared/setpoint_seq_defines.svh
// constants for the program set point sequencer
`ifndef SETPOINT_SEQ_DEFINES_SVH
`define SETPOINT_SEQ_DEFINES_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SEQ_OFF_CTRL 12'h000
`define SEQ_OFF_MASK 12'h004
`define SEQ_OFF_STAT 12'h008
`define SEQ_OFF_OUT 12'h00c
`define SEQ_OFF_TABLE 12'h040
`define SEQ_TABLE_MASK 12'hfc0
// ----------------------------------------
// control bit positions
// ----------------------------------------
`define SEQ_CTRL_MODE 0
`define SEQ_CTRL_LOOP 1
`define SEQ_CTRL_SRC 2
`define SEQ_CTRL_RUN 3
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SEQ_MASK_RESET 16'hffff
`define SEQ_CLK_HZ 125000000
`define SEQ_TICK_NS 1000000
`define SEQ_CLK_NS 8
`define SEQ_TICK_CYCLES (`SEQ_TICK_NS / `SEQ_CLK_NS)
`define SEQ_MS_PER_S 1000
`endif

// File: shared/setpoint_seq_pkg.sv
// types for the program set point sequencer
package setpoint_seq_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_RAMP = 2'b11,
		ST_HOLD = 2'b10
	} seq_state_e;

	typedef struct packed {
		logic [15:0] target;
		logic [15:0] seconds;
	} step_s;

	typedef struct packed {
		logic mode;
		logic loop;
		logic src;
		logic run;
	} ctrl_s;
endpackage : setpoint_seq_pkg

// File: hdl/program_setpoint_sequencer.sv
// program set point sequencer with apb register access
// Function
// - table of sixteen steps, each a percent target and seconds interval
// - ramp output linearly from present value to target over step time
// - program mode setting, enabled or disabled, disabled after reset
// - with looping, restart at first unmasked step after last; loop off default
// - masked steps skipped to next unmasked one; all unmasked by default
// - step mask register holds one enable bit per step
// - run only with mode enabled, source program, run flag on; run off default
// - clearing run pauses and freezes set point; setting run resumes
// - accepted mask and step values retained in non-volatile storage; here the mask resets to all ones, only the step table survives reset
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "setpoint_seq_defines.svh"

module program_setpoint_sequencer
	import setpoint_seq_pkg::*;
#(
	parameter int STEPS = 16,
	parameter int TICK_CYCLES = `SEQ_TICK_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// set point to the flow loop
	output logic [15:0] setpoint,
	output logic seq_active,
	// non-volatile store write notice
	output logic nv_store
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	ctrl_s ctrl_reg;
	logic [STEPS-1:0] mask_reg;
	step_s table_mem [STEPS];
	seq_state_e state_reg, state_next;
	logic [3:0] step_reg;
	logic [15:0] sp_reg;
	logic [15:0] start_reg;
	logic [15:0] target_reg;
	logic [31:0] ms_total_reg;
	logic [31:0] ms_count_reg;
	logic [31:0] tick_reg;
	logic nv_reg;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire logic wr = psel & penable & pwrite;
	wire logic hit_ctrl = paddr == `SEQ_OFF_CTRL;
	wire logic hit_mask = paddr == `SEQ_OFF_MASK;
	wire logic hit_stat = paddr == `SEQ_OFF_STAT;
	wire logic hit_out = paddr == `SEQ_OFF_OUT;
	wire logic hit_tab = (paddr & `SEQ_TABLE_MASK) == `SEQ_OFF_TABLE;
	wire logic [3:0] tab_idx = paddr[5:2];
	wire logic hit_any = hit_ctrl | hit_mask | hit_stat | hit_out | hit_tab;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit_any;

	// next enabled step at or after a start index
	function automatic logic [4:0] next_enabled(input logic [STEPS-1:0] m,
			input logic [4:0] from);
		logic [4:0] r;
		r = 5'h10;
		for (int i = STEPS - 1; i >= 0; i--) begin
			if (m[i] && i >= from) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction : next_enabled

	wire logic go = ctrl_reg.mode & ctrl_reg.src & ctrl_reg.run;
	wire logic enabled = ctrl_reg.mode & ctrl_reg.src;
	wire logic [4:0] first_step = next_enabled(mask_reg, 5'h00);
	wire logic [4:0] after_step = next_enabled(mask_reg, 5'({1'b0, step_reg} + 5'h01));
	wire logic tick = tick_reg == 32'(TICK_CYCLES - 1);
	wire logic ramp_done = ms_count_reg >= ms_total_reg;
	wire step_s cur_step = table_mem[step_reg];

	// linear interpolation from start to target
	wire logic signed [17:0] span = 18'($signed({2'b00, target_reg}) - $signed({2'b00, start_reg}));
	wire logic signed [49:0] prod = 50'(span * $signed({1'b0, ms_count_reg}));
	wire logic signed [49:0] quot = (ms_total_reg == 32'h0) ? 50'(span) :
		50'(prod / $signed({18'h0, ms_total_reg}));
	wire logic [15:0] ramp_val = 16'($signed({2'b00, start_reg}) + 18'(quot));

	// ----------------------------------------
	// sequencer state machine
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (go && first_step != 5'h10) begin
					state_next = ST_LOAD;
				end
			end
			ST_LOAD: state_next = ST_RAMP;
			ST_RAMP: begin
				if (!enabled) begin
					state_next = ST_IDLE;
				end else if (go && ramp_done) begin
					if (after_step != 5'h10) begin
						state_next = ST_LOAD;
					end else if (ctrl_reg.loop && first_step != 5'h10) begin
						state_next = ST_LOAD;
					end else begin
						state_next = ST_HOLD;
					end
				end
			end
			ST_HOLD: begin
				if (!enabled) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			step_reg <= 4'h0;
			sp_reg <= 16'h0000;
			start_reg <= 16'h0000;
			target_reg <= 16'h0000;
			ms_total_reg <= 32'h0;
			ms_count_reg <= 32'h0;
			tick_reg <= 32'h0;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE && state_next == ST_LOAD) begin
				step_reg <= first_step[3:0];
			end else if (state_reg == ST_RAMP && state_next == ST_LOAD) begin
				step_reg <= (after_step != 5'h10) ? after_step[3:0] : first_step[3:0];
			end
			if (state_reg == ST_LOAD) begin
				start_reg <= sp_reg;
				target_reg <= cur_step.target;
				ms_total_reg <= 32'(cur_step.seconds * `SEQ_MS_PER_S);
				ms_count_reg <= 32'h0;
				tick_reg <= 32'h0;
			end else if (state_reg == ST_RAMP && go) begin
				tick_reg <= tick ? 32'h0 : tick_reg + 32'h1;
				if (tick && !ramp_done) begin
					ms_count_reg <= ms_count_reg + 32'h1;
				end
				sp_reg <= ramp_done ? target_reg : ramp_val;
			end else if (state_reg == ST_HOLD) begin
				sp_reg <= target_reg;
			end
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= '0;
			mask_reg <= STEPS'(`SEQ_MASK_RESET);
			nv_reg <= 1'b0;
		end else begin
			nv_reg <= wr & (hit_mask | hit_tab);
			if (wr && hit_ctrl) begin
				ctrl_reg.mode <= pwdata[`SEQ_CTRL_MODE];
				ctrl_reg.loop <= pwdata[`SEQ_CTRL_LOOP];
				ctrl_reg.src <= pwdata[`SEQ_CTRL_SRC];
				ctrl_reg.run <= pwdata[`SEQ_CTRL_RUN];
			end
			if (wr && hit_mask) begin
				mask_reg <= pwdata[STEPS-1:0];
			end
		end
	end

	// step table, contents survive reset
	always_ff @(posedge sys_clk) begin
		if (wr && hit_tab) begin
			table_mem[tab_idx] <= pwdata;
		end
	end

	// ----------------------------------------
	// read data and outputs
	// ----------------------------------------
	wire step_s rd_step = table_mem[tab_idx];
	wire logic [31:0] rd_mux =
		hit_ctrl ? {28'h0, ctrl_reg.run, ctrl_reg.src, ctrl_reg.loop, ctrl_reg.mode} :
		hit_mask ? 32'(mask_reg) :
		hit_stat ? {24'h0, 2'b00, state_reg, step_reg} :
		hit_out ? {16'h0, sp_reg} :
		hit_tab ? rd_step : 32'h0;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	assign setpoint = sp_reg;
	assign seq_active = (state_reg == ST_RAMP) & go;
	assign nv_store = nv_reg;
endmodule : program_setpoint_sequencer
`default_nettype wire

// File: sim/flow_loop_model.sv
// flow loop model consuming the set point
`timescale 1ns/100ps
`default_nettype none
module flow_loop_model #(
	parameter logic [15:0] WATCH = 16'h03e7
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// set point in, skipped value seen out
	input wire logic [15:0] setpoint,
	output logic saw_watch
);
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) saw_watch <= 1'b0;
		else saw_watch <= saw_watch | (setpoint == WATCH);
	end
endmodule : flow_loop_model
`default_nettype wire

// File: sim/program_setpoint_sequencer_assertions.sv
// port checker for the set point sequencer
`timescale 1ns/100ps
`default_nettype none
module program_setpoint_sequencer_assertions (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] setpoint,
	input wire logic seq_active,
	input wire logic nv_store
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence acc_s; psel && penable; endsequence
	sequence nv_wr_s; acc_s ##0 (pwrite && (paddr == 12'h004 || paddr[11:6] == 6'h01)); endsequence
	ready_high_a: assert property (psel |-> pready) else $error("pready low");
	err_scope_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
	unmapped_err_a: assert property (acc_s ##0 (paddr == 12'h010) |-> pslverr) else $error("no pslverr");
	ctrl_ok_a: assert property (acc_s ##0 (paddr == 12'h000) |-> !pslverr) else $error("ctrl err");
	nv_after_a: assert property (nv_wr_s |=> nv_store) else $error("no store notice");
	nv_pulse_a: assert property (nv_store |=> !nv_store) else $error("long store notice");
	nv_cause_a: assert property (nv_store |-> $past(psel && penable && pwrite)) else $error("store no write");
	idle_hold_a: assert property (!seq_active ##1 !seq_active |-> $stable(setpoint)) else $error("set point moved");
endmodule : program_setpoint_sequencer_assertions
bind program_setpoint_sequencer program_setpoint_sequencer_assertions chk (.sys_clk, .nrst,
	.psel, .penable, .pwrite, .paddr, .pready, .pslverr, .setpoint, .seq_active, .nv_store);
`default_nettype wire

// File: sim/program_setpoint_sequencer_test.sv
// testbench for the set point sequencer
`timescale 1ns/100ps
`default_nettype none
module program_setpoint_sequencer_test;
	import setpoint_seq_pkg::*;
	logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, err, saw;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, rd0;
	logic pready, pslverr, seq_active, nv_store;
	logic [15:0] setpoint;
	int miscompares = 0, total_checks = 0;
	localparam int TICKS = 2;
	time t0;
	program_setpoint_sequencer #(.TICK_CYCLES(TICKS)) dut (.sys_clk, .nrst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .setpoint, .seq_active, .nv_store);
	flow_loop_model far (.sys_clk, .nrst, .setpoint, .saw_watch(saw));
	initial forever #4 sys_clk = ~sys_clk;
	task automatic stop_test();
		if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		for (i = 0; i < 9; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		if (i == 9) begin miscompares++; stop_test(); end
		rd = prdata; err = pslverr;
		psel <= 0; penable <= 0;
	endtask : apb
	task automatic wait_sp(input logic [15:0] v);
		int i;
		for (i = 0; i < 5000 && setpoint !== v; i++) @(posedge sys_clk);
		if (i == 5000) begin miscompares++; stop_test(); end
	endtask : wait_sp
	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1;
		apb(0, 12'h000, 0); check(rd, 32'h0);
		apb(0, 12'h004, 0); check(rd, 32'h0000ffff);
		apb(0, 12'h010, 0); check({31'h0, err}, 32'h1);
		apb(1, 12'h040, {16'h0064, 16'h0000});
		apb(1, 12'h044, {16'h00c8, 16'h0001});
		apb(1, 12'h048, {16'h03e7, 16'h0000});
		apb(1, 12'h04c, {16'h0032, 16'h0000});
		apb(1, 12'h07c, {16'h1234, 16'h0005});
		apb(0, 12'h07c, 0); check(rd, 32'h12340005);
		apb(1, 12'h004, 32'h0000000b);
		apb(0, 12'h004, 0); check(rd, 32'h0000000b);
		apb(1, 12'h000, 32'h9);
		repeat (20) @(posedge sys_clk);
		check({31'h0, seq_active}, 32'h0);
		apb(1, 12'h000, 32'hd);
		repeat (900) @(posedge sys_clk);
		check({31'h0, seq_active}, 32'h1);
		apb(1, 12'h000, 32'h5);
		apb(0, 12'h00c, 0); rd0 = rd;
		check({31'h0, rd0[15:0] > 16'h0064 && rd0[15:0] < 16'h00c8}, 32'h1);
		repeat (20) @(posedge sys_clk);
		apb(0, 12'h00c, 0); check(rd, rd0);
		apb(1, 12'h000, 32'hd);
		wait_sp(16'h0032);
		repeat (20) @(posedge sys_clk);
		check({16'h0, setpoint}, 32'h32);
		check({31'h0, saw}, 32'h0);
		apb(0, 12'h008, 0); check(rd, 32'h00000023);
		apb(1, 12'h000, 32'h0);
		apb(1, 12'h000, 32'hf);
		wait_sp(16'h0096);
		t0 = $time;
		wait_sp(16'h00c8);
		check(32'(($time - t0) / 8), 32'(500 * TICKS));
		wait_sp(16'h0064); check({16'h0, setpoint}, 32'h64);
		stop_test();
	end
endmodule : program_setpoint_sequencer_test
`default_nettype wire
